// file: rtl/lpm_map.svh
// constants for the low-power and mode controller
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH
// mode strap encodings {mode_pin_b, mode_pin_a}
`define LPM_STRAP_BOOT 2'h0
`define LPM_STRAP_TEST 2'h1
`define LPM_STRAP_SINGLE 2'h2
`define LPM_STRAP_EXPANDED 2'h3
// wake cause codes
`define LPM_CAUSE_NONE 3'h0
`define LPM_CAUSE_RESET 3'h1
`define LPM_CAUSE_NMI 3'h2
`define LPM_CAUSE_IRQ 3'h3
`define LPM_CAUSE_WDOG 3'h4
`define LPM_CAUSE_CMON 3'h5
`define LPM_CAUSE_RESUME 3'h6
// event log depth
`define LPM_LOG_DEPTH 8
`define LPM_LOG_AW 3
`endif

// file: rtl/lpm_pkg.sv
// types for the low-power and mode controller
package lpm_pkg;
  typedef enum logic [1:0] {
    LPM_MODE_BOOT,
    LPM_MODE_TEST,
    LPM_MODE_SINGLE,
    LPM_MODE_EXPANDED
  } lpm_mode_e;
  typedef enum logic [1:0] {
    LPM_RUN,
    LPM_HALT,
    LPM_SLEEP
  } lpm_state_e;
endpackage

// file: rtl/lpm_log_if.sv
// write and read ports of the wake event log
interface lpm_log_if;
  logic wr_en;
  logic [2:0] wr_addr;
  logic [2:0] wr_data;
  logic [2:0] rd_addr;
  logic [2:0] rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// file: rtl/lpm_log_mem.sv
// small memory holding the most recent wake causes
`include "lpm_map.svh"
module lpm_log_mem (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // access port
  lpm_log_if.mem log
);
  logic [2:0] cells [`LPM_LOG_DEPTH];
  logic [2:0] rd_q;

  // storage write, no reset on the array
  always_ff @(posedge clk_i) begin
    if (ce_i && log.wr_en) begin
      cells[log.wr_addr] <= log.wr_data;
    end
  end

  // registered read data
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_q <= `LPM_CAUSE_NONE;
    end else if (ce_i) begin
      rd_q <= cells[log.rd_addr];
    end
  end

  assign log.rd_data = rd_q;
endmodule // lpm_log_mem

// file: rtl/lpm_ctrl.sv
// low-power state and operating mode controller for the processor core
//
// What this block does
// R01: enabled deep halt instruction stops all processor clocks until a wake event
// R02: with clock monitor enabled, clocks stopping by deep halt raise a reset
// R03: deep halt ends on low reset, maskable or nonmaskable interrupt pin
// R04: reset pin wake runs the normal reset start-up sequence
// R05: nonmaskable wake with nmi_mask clear services interrupt then resumes after halt
// R06: nonmaskable wake with nmi_mask set resumes at next instruction, no interrupt
// R07: maskable pin wakes halt only with maskable_gate clear, then runs its handler
// R08: deep halt is a no-operation while halt_gate is set
// R09: idle sleep keeps clocks running, stacks machine state, stops instruction processing
// R10: idle sleep ends only on unmasked interrupt or low reset pin
// R11: watchdog, clock monitor, maskable and nonmaskable pins can end idle sleep
// R12: after idle sleep wake, run matching handler then continue after idle_sleep
// R13: software should turn clock monitor off around deep halt
// R14: exactly four operating modes are supported
// R15: mode is chosen from the two strap pins mode_pin_a and mode_pin_b
// R16: expanded mode uses separate address and data lines for external memory
// R17: single chip mode addresses no external memory
// R18: board holds mode_pin_a high; mode_pin_b low selects test recovery mode
// R19: a masked interrupt never ends idle sleep; state stays stacked
`include "lpm_map.svh"
module lpm_ctrl (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // external pins, reset and interrupt pins active low, strap pins active high
  input wire logic reset_pin_n_i,
  input wire logic maskable_int_pin_n_i,
  input wire logic nonmaskable_int_pin_n_i,
  input wire logic mode_pin_a_i,
  input wire logic mode_pin_b_i,
  // internal event sources
  input wire logic watchdog_miss_i,
  input wire logic clock_fail_i,
  input wire logic clock_monitor_en_i,
  // condition_code_register flags
  input wire logic halt_gate_i,
  input wire logic maskable_gate_i,
  input wire logic nmi_mask_i,
  // instruction decode strobes from the core
  input wire logic deep_halt_exec_i,
  input wire logic idle_sleep_exec_i,
  input wire logic stack_done_i,
  // core control
  output logic clocks_run_o,
  output logic stack_state_o,
  output logic core_stall_o,
  output logic reset_req_o,
  output logic take_nmi_o,
  output logic take_irq_o,
  output logic take_wdog_o,
  output logic take_cmon_o,
  output logic resume_o,
  // operating mode
  output logic [1:0] op_mode_o,
  output logic ext_bus_en_o,
  output logic addr_mux_en_o,
  // status
  output logic [1:0] lp_state_o,
  output logic [2:0] last_cause_o
);
  // --------------------------------------------------------------
  // state and wake decode
  // --------------------------------------------------------------
  lpm_pkg::lpm_state_e state;
  lpm_pkg::lpm_state_e next_state;
  logic stacked;
  logic strap_taken;
  logic strap_load;
  logic halt_wake_nmi;
  logic halt_wake_irq;
  logic sleep_wake_nmi;
  logic sleep_wake_irq;
  logic sleep_wake_wdog;
  logic sleep_wake_cmon;
  logic [2:0] next_cause;
  logic [`LPM_LOG_AW-1:0] log_ptr;
  lpm_log_if log_bus ();

  // wake qualifiers for each low-power state
  assign halt_wake_nmi = !nonmaskable_int_pin_n_i; // [R03]
  assign halt_wake_irq = !maskable_int_pin_n_i && !maskable_gate_i; // [R07]
  assign sleep_wake_nmi = !nonmaskable_int_pin_n_i && !nmi_mask_i; // [R11] [R19]
  assign sleep_wake_irq = !maskable_int_pin_n_i && !maskable_gate_i; // [R11] [R19]
  assign sleep_wake_wdog = watchdog_miss_i; // [R11]
  assign sleep_wake_cmon = clock_fail_i; // [R11]

  // next state and wake cause
  always_comb begin
    next_state = state;
    next_cause = `LPM_CAUSE_NONE;
    unique case (state)
      lpm_pkg::LPM_RUN: begin
        if (deep_halt_exec_i && !halt_gate_i) begin
          next_state = lpm_pkg::LPM_HALT; // [R08] [R01]
        end else if (idle_sleep_exec_i) begin
          next_state = lpm_pkg::LPM_SLEEP; // [R09]
        end
      end
      lpm_pkg::LPM_HALT: begin
        if (!reset_pin_n_i) begin
          next_state = lpm_pkg::LPM_RUN; // [R03] [R04]
          next_cause = `LPM_CAUSE_RESET;
        end else if (halt_wake_nmi) begin
          next_state = lpm_pkg::LPM_RUN;
          next_cause = nmi_mask_i ? `LPM_CAUSE_RESUME : `LPM_CAUSE_NMI; // [R05] [R06]
        end else if (halt_wake_irq) begin
          next_state = lpm_pkg::LPM_RUN;
          next_cause = `LPM_CAUSE_IRQ; // [R07]
        end
      end
      lpm_pkg::LPM_SLEEP: begin
        if (!reset_pin_n_i) begin
          next_state = lpm_pkg::LPM_RUN; // [R10]
          next_cause = `LPM_CAUSE_RESET;
        end else if (stacked) begin
          if (sleep_wake_nmi) begin
            next_state = lpm_pkg::LPM_RUN; // [R10] [R12]
            next_cause = `LPM_CAUSE_NMI;
          end else if (sleep_wake_irq) begin
            next_state = lpm_pkg::LPM_RUN;
            next_cause = `LPM_CAUSE_IRQ;
          end else if (sleep_wake_wdog) begin
            next_state = lpm_pkg::LPM_RUN;
            next_cause = `LPM_CAUSE_WDOG;
          end else if (sleep_wake_cmon) begin
            next_state = lpm_pkg::LPM_RUN;
            next_cause = `LPM_CAUSE_CMON;
          end
        end
      end
      default: begin
        next_state = lpm_pkg::LPM_RUN;
      end
    endcase
  end

  // --------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------

  // low-power state
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= lpm_pkg::LPM_RUN;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // stacked flag, cleared on the leaving edge so a quick re-entry stacks again
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stacked <= 1'b0;
    end else if (ce_i) begin
      if (next_state != lpm_pkg::LPM_SLEEP) begin
        stacked <= 1'b0;
      end else if (state == lpm_pkg::LPM_SLEEP && stack_done_i) begin
        stacked <= 1'b1; // [R09]
      end
    end
  end

  // clock gate, clocks stop only in deep halt
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clocks_run_o <= 1'b1;
    end else if (ce_i) begin
      clocks_run_o <= (next_state != lpm_pkg::LPM_HALT); // [R01] [R09]
    end
  end

  // stacking request, held until the core reports the state pushed
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stack_state_o <= 1'b0;
    end else if (ce_i) begin
      stack_state_o <= (next_state == lpm_pkg::LPM_SLEEP) && !stacked && !stack_done_i; // [R09]
    end
  end

  // instruction stall in either low-power state
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      core_stall_o <= 1'b0;
    end else if (ce_i) begin
      core_stall_o <= (next_state != lpm_pkg::LPM_RUN); // [R01] [R09] [R19]
    end
  end

  // reset request: reset pin wake or monitored clock stop
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reset_req_o <= 1'b0;
    end else if (ce_i) begin
      reset_req_o <= (next_cause == `LPM_CAUSE_RESET) ||
                     (state == lpm_pkg::LPM_RUN && next_state == lpm_pkg::LPM_HALT
                      && clock_monitor_en_i); // [R02] [R04] [R13]
    end
  end

  // one-cycle vector strobes on an interrupting wake
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      take_nmi_o <= 1'b0;
      take_irq_o <= 1'b0;
      take_wdog_o <= 1'b0;
      take_cmon_o <= 1'b0;
    end else if (ce_i) begin
      take_nmi_o <= (next_cause == `LPM_CAUSE_NMI); // [R05] [R12]
      take_irq_o <= (next_cause == `LPM_CAUSE_IRQ); // [R07] [R12]
      take_wdog_o <= (next_cause == `LPM_CAUSE_WDOG); // [R12]
      take_cmon_o <= (next_cause == `LPM_CAUSE_CMON); // [R12]
    end
  end

  // one-cycle resume strobe when a masked nonmaskable wake skips the handler
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      resume_o <= 1'b0;
    end else if (ce_i) begin
      resume_o <= (next_cause == `LPM_CAUSE_RESUME); // [R06]
    end
  end

  // last wake cause status
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_cause_o <= `LPM_CAUSE_NONE;
    end else if (ce_i && next_cause != `LPM_CAUSE_NONE) begin
      last_cause_o <= next_cause;
    end
  end

  assign lp_state_o = state;

  // --------------------------------------------------------------
  // operating mode straps
  // --------------------------------------------------------------

  // straps followed while the reset pin is low and on the first edge after reset
  assign strap_load = !strap_taken || !reset_pin_n_i;

  // capture armed until the reset pin is seen high
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_taken <= 1'b0;
    end else if (ce_i && strap_load) begin
      strap_taken <= reset_pin_n_i;
    end
  end

  // operating mode straight from the two strap pins
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_mode_o <= lpm_pkg::LPM_MODE_EXPANDED;
    end else if (ce_i && strap_load) begin
      op_mode_o <= {mode_pin_b_i, mode_pin_a_i}; // [R14] [R15] [R18]
    end
  end

  // external memory bus in every mode but single chip
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_bus_en_o <= 1'b0;
    end else if (ce_i && strap_load) begin
      ext_bus_en_o <= ({mode_pin_b_i, mode_pin_a_i} != `LPM_STRAP_SINGLE); // [R16] [R17]
    end
  end

  // address and data lines stay separate in every mode
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_mux_en_o <= 1'b0;
    end else if (ce_i) begin
      addr_mux_en_o <= 1'b0; // [R16]
    end
  end

  // --------------------------------------------------------------
  // wake event log
  // --------------------------------------------------------------

  // append each wake cause to the log
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      log_ptr <= '0;
    end else if (ce_i && next_cause != `LPM_CAUSE_NONE) begin
      log_ptr <= log_ptr + 1'b1;
    end
  end

  assign log_bus.wr_en = (next_cause != `LPM_CAUSE_NONE);
  assign log_bus.wr_addr = log_ptr;
  assign log_bus.wr_data = next_cause;
  assign log_bus.rd_addr = log_ptr;

  lpm_log_mem u_log (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .log(log_bus.mem)
  );
endmodule // lpm_ctrl

// file: tb/lpm_ctrl_monitor.sv
// concurrent checks on the low-power and mode controller ports
module lpm_ctrl_monitor (
  // clock and reset
  input logic clk_i,
  input logic sys_rst_i,
  // watched inputs
  input logic ce_i,
  input logic reset_pin_n_i,
  input logic maskable_int_pin_n_i,
  input logic nonmaskable_int_pin_n_i,
  input logic mode_pin_a_i,
  input logic mode_pin_b_i,
  input logic watchdog_miss_i,
  input logic clock_fail_i,
  input logic clock_monitor_en_i,
  input logic halt_gate_i,
  input logic maskable_gate_i,
  input logic nmi_mask_i,
  input logic deep_halt_exec_i,
  input logic idle_sleep_exec_i,
  input logic stack_done_i,
  // watched outputs
  input logic clocks_run_o,
  input logic stack_state_o,
  input logic core_stall_o,
  input logic reset_req_o,
  input logic take_nmi_o,
  input logic take_irq_o,
  input logic resume_o,
  input logic ext_bus_en_o,
  input logic addr_mux_en_o,
  input logic [1:0] op_mode_o,
  input logic [1:0] lp_state_o,
  input logic [2:0] last_cause_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // --------------------------------
  // entry into the low-power states
  // --------------------------------
  wire run_go = ce_i && reset_pin_n_i && lp_state_o == 2'h0;
  wire halt_go = run_go && deep_halt_exec_i && !halt_gate_i;
  wire halt_up = ce_i && reset_pin_n_i && lp_state_o == 2'h1;
  // sleeping with the state already stacked
  wire sleep_up = ce_i && reset_pin_n_i && lp_state_o == 2'h2 && !stack_state_o;
  wire [1:0] strap_now = {mode_pin_b_i, mode_pin_a_i};
  halt_entry_a: assert property (halt_go |=> !clocks_run_o && core_stall_o && lp_state_o == 2'h1)
    else $error("deep halt not entered");
  cmon_reset_a: assert property (halt_go && clock_monitor_en_i |=> reset_req_o)
    else $error("no reset on halt with monitor on");
  halt_gated_a: assert property (run_go && deep_halt_exec_i && halt_gate_i && !idle_sleep_exec_i
    |=> lp_state_o == 2'h0)
    else $error("gated halt was taken");
  sleep_entry_a: assert property (run_go && idle_sleep_exec_i && !deep_halt_exec_i && !stack_done_i
    |=> lp_state_o == 2'h2 && stack_state_o && clocks_run_o && core_stall_o)
    else $error("idle sleep entry wrong");
  // --------------------------------
  // wake-up
  // --------------------------------
  nmi_service_a: assert property (halt_up && !nonmaskable_int_pin_n_i && !nmi_mask_i
    |=> take_nmi_o && clocks_run_o)
    else $error("halt nmi wake wrong");
  nmi_resume_a: assert property (halt_up && !nonmaskable_int_pin_n_i && nmi_mask_i
    |=> resume_o && !take_nmi_o)
    else $error("masked nmi wake wrong");
  irq_gated_a: assert property (halt_up && nonmaskable_int_pin_n_i && maskable_gate_i
    |=> lp_state_o == 2'h1)
    else $error("halt left without wake");
  irq_wake_a: assert property (halt_up && nonmaskable_int_pin_n_i && !maskable_int_pin_n_i && !maskable_gate_i
    |=> take_irq_o && clocks_run_o && last_cause_o == 3'h3)
    else $error("halt irq wake wrong");
  pin_reset_a: assert property (ce_i && lp_state_o != 2'h0 && !reset_pin_n_i
    |=> lp_state_o == 2'h0 && last_cause_o == 3'h1)
    else $error("reset pin wake wrong");
  sleep_hold_a: assert property (ce_i && reset_pin_n_i && lp_state_o == 2'h2 && maskable_gate_i && nmi_mask_i
    && !watchdog_miss_i && !clock_fail_i |=> lp_state_o == 2'h2)
    else $error("sleep left on masked source");
  sleep_wake_a: assert property (sleep_up && (watchdog_miss_i || clock_fail_i)
    |=> lp_state_o == 2'h0 && !core_stall_o)
    else $error("sleep not ended by internal event");
  // --------------------------------
  // operating mode
  // --------------------------------
  strap_mode_a: assert property (ce_i && !reset_pin_n_i |=> op_mode_o == $past(strap_now))
    else $error("mode not taken from straps");
  mode_bus_a: assert property (!addr_mux_en_o && !(op_mode_o == 2'h2 && ext_bus_en_o))
    else $error("bus enables wrong for mode");
endmodule // lpm_ctrl_monitor

bind lpm_ctrl lpm_ctrl_monitor mon_u (.*);

// file: tb/lpm_pins_model.sv
// far-side sources: reset pin, interrupt pins, straps and event lines
module lpm_pins_model (
  // source choice and strap setting from the bench
  input logic [2:0] sel_i,
  input logic [1:0] strap_i,
  // lines toward the controller
  output logic reset_n_o,
  output logic nmi_n_o,
  output logic irq_n_o,
  output logic wdog_o,
  output logic cfail_o,
  output logic mode_a_o,
  output logic mode_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // chosen source pulls its pin low, or drives its event line high; released pins return high by pull-up
  assign reset_n_o = sel_i != 3'h1;
  assign nmi_n_o = sel_i != 3'h2;
  assign irq_n_o = sel_i != 3'h3;
  assign wdog_o = sel_i == 3'h4;
  assign cfail_o = sel_i == 3'h5;
  // board ties strap a high; the bench overrides it only for the mode sweep
  assign mode_a_o = strap_i[0];
  assign mode_b_o = strap_i[1];
endmodule // lpm_pins_model

// file: tb/lpm_ctrl_tb.sv
// self-checking bench for the low-power and mode controller
module lpm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, sys_rst_i = 1, ce_i = 1, reset_pin_n_i, maskable_int_pin_n_i, nonmaskable_int_pin_n_i;
  logic mode_pin_a_i, mode_pin_b_i, watchdog_miss_i, clock_fail_i, clock_monitor_en_i = 0;
  logic halt_gate_i = 1, maskable_gate_i = 1, nmi_mask_i = 1;
  logic deep_halt_exec_i = 0, idle_sleep_exec_i = 0, stack_done_i = 0;
  logic clocks_run_o, stack_state_o, core_stall_o, reset_req_o, take_nmi_o, take_irq_o;
  logic take_wdog_o, take_cmon_o, resume_o, ext_bus_en_o, addr_mux_en_o;
  logic [1:0] op_mode_o, lp_state_o;
  logic [2:0] last_cause_o, sel = 0;
  logic [1:0] strap = 2'h3;
  logic [5:0] exp_q[$];
  int n_errors = 0, checks = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  lpm_ctrl dut_u (.*);
  lpm_pins_model pins_u (.sel_i(sel), .strap_i(strap), .reset_n_o(reset_pin_n_i), .nmi_n_o(nonmaskable_int_pin_n_i),
    .irq_n_o(maskable_int_pin_n_i), .wdog_o(watchdog_miss_i), .cfail_o(clock_fail_i), .mode_a_o(mode_pin_a_i),
    .mode_b_o(mode_pin_b_i));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // one decode strobe, deep halt when h is set, else idle sleep
  task automatic enter(input logic h);
    deep_halt_exec_i = h;
    idle_sleep_exec_i = !h;
    tick(1);
    deep_halt_exec_i = 0;
    idle_sleep_exec_i = 0;
    tick(1);
  endtask
  // one source active for one cycle, then released
  task automatic wake(input logic [2:0] s);
    sel = s;
    tick(1);
    sel = 0;
    tick(1);
  endtask
  task automatic test_done;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watcher: every result pulse is matched against the oldest note; also cuts a hang
  always @(posedge clk_i) begin
    #1;
    cyc++;
    if (!sys_rst_i && {reset_req_o, take_nmi_o, take_irq_o, take_wdog_o, take_cmon_o, resume_o} !== 6'h0)
      check({reset_req_o, take_nmi_o, take_irq_o, take_wdog_o, take_cmon_o, resume_o},
        exp_q.size() ? exp_q.pop_front() : 6'h0);
    if (cyc == 3000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h481aa30e));
    tick(12);
    sys_rst_i = 0;
    tick(2);
    // strap sweep while the reset pin is held low
    for (int m = 0; m < 4; m++) begin
      strap = m[1:0];
      sel = 3'h1;
      tick(2);
      check(op_mode_o, m[7:0]);
      check(ext_bus_en_o, m != 2);
      sel = 0;
      tick(1);
    end
    check(addr_mux_en_o, 0);
    // halt refused, then halt with the monitor on, nmi wake
    enter(1);
    check(lp_state_o, 0);
    halt_gate_i = 0;
    clock_monitor_en_i = 1;
    exp_q.push_back(6'h20);
    enter(1);
    check({clocks_run_o, core_stall_o}, 1);
    clock_monitor_en_i = 0;
    nmi_mask_i = 0;
    exp_q.push_back(6'h10);
    wake(2);
    check({clocks_run_o, last_cause_o}, 8'h0a);
    // masked halt: irq and internal events ignored, masked nmi resumes
    nmi_mask_i = 1;
    enter(1);
    wake(3);
    wake(4);
    wake(5);
    check(lp_state_o, 1);
    // clock enable low freezes the halt against a wake pin
    ce_i = 0;
    wake(2);
    check(lp_state_o, 1);
    ce_i = 1;
    exp_q.push_back(6'h01);
    wake(2);
    check(lp_state_o, 0);
    maskable_gate_i = 0;
    enter(1);
    exp_q.push_back(6'h08);
    wake(3);
    enter(1);
    exp_q.push_back(6'h20);
    wake(1);
    check({lp_state_o, last_cause_o}, 8'h01);
    // idle sleep woken by the nmi, irq, watchdog and clock fail sources in turn
    maskable_gate_i = 1;
    for (int k = 2; k < 6; k++) begin
      enter(0);
      check({clocks_run_o, core_stall_o, stack_state_o, lp_state_o}, 8'h1e);
      wake(k[2:0]);
      // random source before stacking is finished must be ignored
      wake(3'($urandom_range(2, 5)));
      tick($urandom_range(0, 3));
      stack_done_i = 1;
      tick(1);
      stack_done_i = 0;
      check(stack_state_o, 0);
      wake(2);
      wake(3);
      check(lp_state_o, 2);
      maskable_gate_i = 0;
      nmi_mask_i = 0;
      exp_q.push_back(6'h20 >> (k - 1));
      wake(k[2:0]);
      check(lp_state_o, 0);
      maskable_gate_i = 1;
      nmi_mask_i = 1;
    end
    tick(3);
    check(8'(exp_q.size()), 0);
    test_done();
  end
endmodule // lpm_ctrl_tb
